// >>> rtl/adc_seq_defs.svh
/*
 * offsets, field positions, reset values and timing counts of the conversion sequencer.
 * assumes a 100 MHz pclk and a 32-bit apb register bus.
 */
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define NUM_CH 4
`define CH_BITS 2
`define RES_BITS 10
`define AIN_BITS 12
`define SCALE_SHIFT 10
`define WORD_BITS 16

`define ADDR_CTRL 8'h00
`define ADDR_CFG 8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_MASK 8'h0c
`define ADDR_RESULT0 8'h10
`define ADDR_RESULT3 8'h1c

`define CTRL_START_BIT 0
`define CTRL_SCAN_BIT 1
`define CTRL_MASK_LSB 2
`define CTRL_MASK_MSB 5
`define CTRL_FLAG_BIT 8
`define CFG_TIME_LSB 0
`define CFG_TIME_MSB 1
`define CFG_EXT_BIT 2
`define CFG_TIME_OK_BIT 8
`define IRQ_END_BIT 0

`define CTRL_MASK_RST 4'h1
`define CFG_TIME_RST 2'h0

`define CONV_CYC_0 10'd530
`define CONV_CYC_1 10'd266
`define CONV_CYC_2 10'd134
`define CONV_CYC_3 10'd68

`define CLK_PERIOD_NS 10
`define MIN_CONV_NS 8400
`define MIN_CONV_CYC ((`MIN_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/adc_seq_pkg.sv
/*
 * types used by the conversion sequencer and imported by its bench; the approximation core uses none of them.
 * assumes adc_seq_defs.svh is on the include path.
 */
`include "adc_seq_defs.svh"

package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } state_t;

    typedef struct packed {
        logic scan;
        logic [`NUM_CH-1:0] ch_mask;
    } ctrl_t;

    typedef struct packed {
        logic ext_sel;
        logic [1:0] time_sel;
    } cfg_t;

    typedef struct packed {
        logic wrap;
        logic [`CH_BITS-1:0] ch;
    } ch_pick_t;

endpackage : adc_seq_pkg

// >>> rtl/sar_core.sv
/*
 * successive-approximation core: one conversion of a held input against a reference.
 * assumes the input code and reference are sampled on pclk by an upstream sample-and-hold.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module sar_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [9:0] cycles,
    input wire logic [`AIN_BITS-1:0] vin,
    input wire logic [`AIN_BITS-1:0] vref,
    output logic done,
    output logic [`RES_BITS-1:0] result
);

    logic [9:0] cnt_q;
    logic busy_q;
    logic [`RES_BITS-1:0] bit_q;
    logic [`AIN_BITS-1:0] vin_q;
    logic [`AIN_BITS-1:0] vref_q;
    logic [`RES_BITS+`AIN_BITS:0] trial_prod;
    logic [`RES_BITS+`AIN_BITS:0] vin_scaled;

    // trial code times reference against input times 1024
    assign trial_prod = 23'((result | bit_q) * vref_q);
    assign vin_scaled = 23'({vin_q, 10'h000});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            cnt_q <= 10'h000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q <= cycles - 10'h001;
            end else if (abort) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 10'h001;
                if (cnt_q == 10'h001) begin
                    done <= 1'b1;
                    busy_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 10'h000;
            bit_q <= 10'h000;
            vin_q <= 12'h000;
            vref_q <= 12'h000;
        end else if (start) begin
            result <= 10'h000;
            bit_q <= 10'h200;
            vin_q <= vin;
            vref_q <= vref;
        end else if (bit_q != 10'h000) begin
            if (trial_prod <= vin_scaled) begin
                result <= result | bit_q;
            end
            bit_q <= bit_q >> 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    a_code_floor: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> 23'(result * vref_q) <= vin_scaled)
        else $error("result code above input over reference");

endmodule : sar_core
`default_nettype wire

// >>> rtl/adc_conversion_sequencer.sv
/*
 * conversion sequencer: apb registers, start sources, channel order, results, interrupt.
 * assumes analog inputs arrive as pclk-domain codes and ext_trigger_n is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

// Function
// - In single mode the sequencer halts by itself once the selected channels are converted.
// - That halt leaves the conversion end flag set until software writes a stop.
// - Writing a stop through the start bit clears the conversion end flag, unless a pass ends in the same cycle.
// - With the end interrupt enabled every completed conversion pass raises the interrupt.
// - Scan mode repeats the channel group without end, interrupting at each pass, until stopped.
// - Selected channels convert in ascending order; in scan mode they wrap to the lowest after the highest.
// - With the external source selected a falling edge on the trigger pin starts conversion.
// - Each result code is the input over the reference scaled by 1024, ten bits wide.
// - Results read as 32-bit words whose upper 22 bits are zero.
// - Each channel's result lands in its own result register for software to read.
// - Time select 0 to 3 picks 530, 266, 134 or 68 clock cycles per conversion.
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trigger_n,
    input wire logic [`NUM_CH-1:0][`AIN_BITS-1:0] ain,
    input wire logic [`AIN_BITS-1:0] vref,
    output logic irq
);

    state_t state_q;
    ctrl_t ctrl_q;
    cfg_t cfg_q;
    logic [`CH_BITS-1:0] ch_q;
    logic conversion_end_flag_q;
    logic irq_stat_q;
    logic irq_mask_q;
    logic [`NUM_CH-1:0][`RES_BITS-1:0] result_regs_q;
    logic trig_meta_q;
    logic trig_sync_q;
    logic trig_prev_q;
    logic wr_en;
    logic rd_en;
    logic stop_wr;
    logic sw_start;
    logic ext_fall;
    logic go;
    logic [`NUM_CH-1:0] start_mask;
    logic core_start;
    logic core_done;
    logic [`RES_BITS-1:0] core_result;
    logic [9:0] conv_cycles;
    logic group_end;
    logic halt_now;
    ch_pick_t pick;
    logic [31:0] rd_d;
    logic rd_err;

    ////////////////////////////////////////////////////////////////////////////
    // channel order helpers

    function automatic ch_pick_t next_ch(input logic [`NUM_CH-1:0] mask,
                                         input logic [`CH_BITS-1:0] cur);
        ch_pick_t p;
        logic found;
        p.wrap = 1'b1;
        p.ch = cur;
        found = 1'b0;
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && (i > int'(cur))) begin
                p.ch = `CH_BITS'(i);
                found = 1'b1;
            end
        end
        if (!found) begin
            for (int i = `NUM_CH - 1; i >= 0; i--) begin
                if (mask[i]) begin
                    p.ch = `CH_BITS'(i);
                end
            end
        end
        p.wrap = ~found;
        return p;
    endfunction : next_ch

    function automatic logic [`CH_BITS-1:0] first_ch(input logic [`NUM_CH-1:0] mask);
        logic [`CH_BITS-1:0] c;
        c = '0;
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (mask[i]) begin
                c = `CH_BITS'(i);
            end
        end
        return c;
    endfunction : first_ch

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;
    assign stop_wr = wr_en && (paddr == `ADDR_CTRL) && !pwdata[`CTRL_START_BIT];
    assign sw_start = wr_en && (paddr == `ADDR_CTRL) && pwdata[`CTRL_START_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == `ADDR_CTRL) begin
            rd_d[`CTRL_START_BIT] = (state_q == ST_CONV);
            rd_d[`CTRL_SCAN_BIT] = ctrl_q.scan;
            rd_d[`CTRL_MASK_MSB:`CTRL_MASK_LSB] = ctrl_q.ch_mask;
            rd_d[`CTRL_FLAG_BIT] = conversion_end_flag_q;
        end else if (paddr == `ADDR_CFG) begin
            rd_d[`CFG_TIME_MSB:`CFG_TIME_LSB] = cfg_q.time_sel;
            rd_d[`CFG_EXT_BIT] = cfg_q.ext_sel;
            rd_d[`CFG_TIME_OK_BIT] = (32'(conv_cycles) >= 32'(`MIN_CONV_CYC));
        end else if (paddr == `ADDR_IRQ_STAT) begin
            rd_d[`IRQ_END_BIT] = irq_stat_q;
        end else if (paddr == `ADDR_IRQ_MASK) begin
            rd_d[`IRQ_END_BIT] = irq_mask_q;
        end else if ((paddr >= `ADDR_RESULT0) && (paddr <= `ADDR_RESULT3) &&
                     (paddr[1:0] == 2'b00)) begin
            rd_d[`RES_BITS-1:0] = result_regs_q[paddr[3:2]];
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= rd_err;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '{scan: 1'b0, ch_mask: `CTRL_MASK_RST};
            cfg_q <= '{ext_sel: 1'b0, time_sel: `CFG_TIME_RST};
            irq_mask_q <= 1'b0;
        end else if (wr_en) begin
            if (paddr == `ADDR_CTRL) begin
                ctrl_q.scan <= pwdata[`CTRL_SCAN_BIT];
                ctrl_q.ch_mask <= pwdata[`CTRL_MASK_MSB:`CTRL_MASK_LSB];
            end else if (paddr == `ADDR_CFG) begin
                cfg_q.time_sel <= pwdata[`CFG_TIME_MSB:`CFG_TIME_LSB];
                cfg_q.ext_sel <= pwdata[`CFG_EXT_BIT];
            end else if (paddr == `ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[`IRQ_END_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external trigger: two-stage sync then falling edge

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta_q <= 1'b1;
            trig_sync_q <= 1'b1;
            trig_prev_q <= 1'b1;
        end else begin
            trig_meta_q <= ext_trigger_n;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end

    assign ext_fall = trig_prev_q & ~trig_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        case (cfg_q.time_sel)
            2'd0: conv_cycles = `CONV_CYC_0;
            2'd1: conv_cycles = `CONV_CYC_1;
            2'd2: conv_cycles = `CONV_CYC_2;
            default: conv_cycles = `CONV_CYC_3;
        endcase
    end

    // a start write brings its own channel mask
    assign start_mask = (wr_en && (paddr == `ADDR_CTRL)) ?
        pwdata[`CTRL_MASK_MSB:`CTRL_MASK_LSB] : ctrl_q.ch_mask;
    assign go = (state_q == ST_IDLE) && (start_mask != '0) && !stop_wr &&
                (sw_start || (cfg_q.ext_sel && ext_fall));
    assign pick = next_ch(ctrl_q.ch_mask, ch_q);
    assign group_end = (state_q == ST_CONV) && core_done && pick.wrap;
    assign halt_now = group_end && !ctrl_q.scan;
    assign core_start = go ||
        ((state_q == ST_CONV) && core_done && !halt_now && !stop_wr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ch_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_CONV;
                        ch_q <= first_ch(start_mask);
                    end
                end
                ST_CONV: begin
                    if (stop_wr || halt_now) begin
                        state_q <= ST_IDLE;
                    end else if (core_done) begin
                        ch_q <= pick.ch;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // result storage per channel
    generate
        for (genvar g = 0; g < `NUM_CH; g++) begin : g_result
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    result_regs_q[g] <= '0;
                end else if ((state_q == ST_CONV) && core_done &&
                             (ch_q == `CH_BITS'(g))) begin
                    result_regs_q[g] <= core_result;
                end
            end
        end
    endgenerate

    // end flag: set beats the stop clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_end_flag_q <= 1'b0;
        end else if (group_end) begin
            conversion_end_flag_q <= 1'b1;
        end else if (stop_wr) begin
            conversion_end_flag_q <= 1'b0;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 1'b0;
        end else if (group_end) begin
            irq_stat_q <= 1'b1;
        end else if (wr_en && (paddr == `ADDR_IRQ_STAT) && pwdata[`IRQ_END_BIT]) begin
            irq_stat_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_stat_q & irq_mask_q;
        end
    end

    sar_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .start(core_start),
        .abort(stop_wr),
        .cycles(conv_cycles),
        .vin(ain[core_start ? (go ? first_ch(start_mask) : pick.ch) : ch_q]),
        .vref(vref),
        .done(core_done),
        .result(core_result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [9:0] per_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q <= 10'h000;
        end else if (core_start) begin
            per_cnt_q <= 10'h001;
        end else if (per_cnt_q != 10'h000) begin
            per_cnt_q <= per_cnt_q + 10'h001;
        end
    end

    a_single_halt: assert property (
        halt_now && !stop_wr |=> state_q == ST_IDLE && !u_core.busy_q)
        else $error("single mode did not halt after last channel");
    a_flag_holds: assert property (
        conversion_end_flag_q && !stop_wr |=> conversion_end_flag_q)
        else $error("end flag dropped without a stop");
    a_stop_clears: assert property (
        stop_wr && !group_end |=> !conversion_end_flag_q)
        else $error("stop did not clear end flag");
    a_end_irq: assert property (
        group_end && irq_mask_q && !(wr_en && paddr == `ADDR_IRQ_MASK) |-> ##2 irq)
        else $error("end interrupt not raised");
    a_scan_repeat: assert property (
        group_end && ctrl_q.scan && !stop_wr |=> state_q == ST_CONV && u_core.busy_q)
        else $error("scan mode did not continue");
    a_ascend_order: assert property (
        core_done && state_q == ST_CONV && !pick.wrap && !stop_wr |=> ch_q > $past(ch_q))
        else $error("channel order not ascending");
    a_ext_start: assert property (
        cfg_q.ext_sel && ext_fall && state_q == ST_IDLE && start_mask != '0
        && !stop_wr |=> state_q == ST_CONV)
        else $error("falling trigger edge did not start");
    a_result_upper: assert property (
        rd_en && paddr >= `ADDR_RESULT0 |=> prdata[31:`RES_BITS] == '0)
        else $error("result upper bits not zero");
    a_result_store: assert property (
        core_done && state_q == ST_CONV |=> result_regs_q[$past(ch_q)] == $past(core_result))
        else $error("result not stored in channel register");
    a_conv_period: assert property (
        core_done |-> per_cnt_q == conv_cycles)
        else $error("conversion time not as selected");
    a_start_busy: assert property (
        rd_en && paddr == `ADDR_CTRL && state_q == ST_CONV && !core_done
        |=> prdata[`CTRL_START_BIT])
        else $error("start bit not read as busy");

    c_single_end: cover property (halt_now);
    c_scan_wrap: cover property (group_end && ctrl_q.scan);
    c_ext_start: cover property (go && !sw_start);
    c_stop_busy: cover property (stop_wr && state_q == ST_CONV);

endmodule : adc_conversion_sequencer
`default_nettype wire

// >>> bench/adc_front_model.sv
/*
 * far side of the sequencer: channel codes, reference code and external trigger pin.
 * assumes the bench calls fire_trigger from its own sequence.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_front_model (
    input wire logic pclk,
    output logic [`NUM_CH-1:0][`AIN_BITS-1:0] ain,
    output logic [`AIN_BITS-1:0] vref,
    output logic ext_trigger_n
);
    // distinct code per channel; ch3 saturates
    initial begin
        ain = {12'hfff, 12'h0c0, 12'h300, 12'h600};
        vref = 12'hc00;
        ext_trigger_n = 1'b1;
    end

    // pin idles high; low held well past the synchroniser
    task automatic fire_trigger();
        @(posedge pclk);
        ext_trigger_n <= 1'b0;
        repeat (6) @(posedge pclk);
        ext_trigger_n <= 1'b1;
    endtask : fire_trigger
endmodule : adc_front_model
`default_nettype wire

// >>> bench/adc_conversion_sequencer_tb.sv
/*
 * self-checking bench of the conversion sequencer: apb tasks and test sequences.
 * assumes the design's defs header and package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_conversion_sequencer_tb
    import adc_seq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ext_trigger_n, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [`NUM_CH-1:0][`AIN_BITS-1:0] ain;
    logic [`AIN_BITS-1:0] vref;
    int err_count, samples_checked, cyc;
    time tstart;
    int ncyc[4] = '{530, 266, 134, 68};
    // input code over reference times 1024, capped at ten bits
    logic [31:0] res_x[4] = '{32'h200, 32'h100, 32'h40, 32'h3ff};

    adc_conversion_sequencer DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trigger_n(ext_trigger_n), .ain(ain), .vref(vref), .irq(irq)
    );

    adc_front_model front (
        .pclk(pclk), .ain(ain), .vref(vref), .ext_trigger_n(ext_trigger_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // setup, access, hold until pready sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check({31'h0, n < 50}, 32'h1, "apb answer");
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdat, exp, "read");
    endtask : rd

    // cycles from the start edge to irq high
    task automatic wait_irq(input int lim);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (irq !== 1'b1 && k < lim);
        cyc = int'(($time - tstart) / 10);
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_CTRL, 32'h4);
        rd(`ADDR_CFG, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, rerr}, 32'h1, "unmapped error");
        check(rdat, 32'h0, "unmapped data");
        $display("test reset done");

        // ch1 and ch3 only, single pass
        apb(1'b1, `ADDR_CFG, 32'h3);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, `ADDR_CTRL, 32'h29);
        tstart = $time;
        repeat (70) @(posedge pclk);
        rd(`ADDR_RESULT0 + 8'h04, 32'h100);
        rd(`ADDR_RESULT3, 32'h0);
        wait_irq(300);
        check(32'(cyc), 32'd137, "two channel pass");
        rd(`ADDR_RESULT3, 32'h3ff);
        rd(`ADDR_RESULT0, 32'h0);
        apb(1'b1, `ADDR_CTRL, 32'h28);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
        $display("test order done");

        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `ADDR_CFG, 32'(s));
            apb(1'b1, `ADDR_CTRL, 32'h5);
            tstart = $time;
            if (s == 0) begin
                // second start mid-conversion must not restart the count
                rd(`ADDR_CTRL, 32'h5);
                apb(1'b1, `ADDR_CTRL, 32'h5);
            end
            wait_irq(600);
            check(32'(cyc), 32'(ncyc[s] + 1), "conversion time");
            rd(`ADDR_CTRL, 32'h104);
            rd(`ADDR_RESULT0, 32'h200);
            apb(1'b1, `ADDR_CTRL, 32'h4);
            rd(`ADDR_CTRL, 32'h4);
            apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
            rd(`ADDR_IRQ_STAT, 32'h0);
            check({31'h0, irq}, 32'h0, "irq after clear");
        end
        $display("test timing done");

        apb(1'b1, `ADDR_CFG, 32'h3);
        apb(1'b1, `ADDR_CTRL, 32'h3f);
        tstart = $time;
        rd(`ADDR_CTRL, 32'h3f);
        wait_irq(400);
        check(32'(cyc), 32'd273, "first scan pass");
        apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
        for (int c = 0; c < 4; c++) begin
            rd(`ADDR_RESULT0 + 8'(4 * c), res_x[c]);
        end
        wait_irq(400);
        check(32'(cyc), 32'd545, "second scan pass");
        apb(1'b1, `ADDR_CTRL, 32'h3c);
        rd(`ADDR_CTRL, 32'h3c);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
        $display("test scan done");

        apb(1'b1, `ADDR_CFG, 32'h7);
        apb(1'b1, `ADDR_CTRL, 32'h4);
        rd(`ADDR_CTRL, 32'h4);
        front.fire_trigger();
        tstart = $time;
        wait_irq(100);
        rd(`ADDR_CTRL, 32'h104);
        apb(1'b1, `ADDR_CTRL, 32'h4);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
        $display("test trigger done");

        apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, `ADDR_CFG, 32'h3);
        apb(1'b1, `ADDR_CTRL, 32'h5);
        repeat (80) @(posedge pclk);
        #1;
        check({31'h0, irq}, 32'h0, "masked irq");
        rd(`ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
        rd(`ADDR_IRQ_STAT, 32'h0);
        $display("test mask done");
        final_report();
    end

    initial begin
        #100000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
